// ### core/tmw_edge_sync.sv
// Two-stage synchroniser with rising edge detector
`timescale 1ns/100ps
module tmw_edge_sync (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta_q; // First stage, read only by second
  logic sync_q; // Second stage
  logic prev_q; // Delayed copy for edge detect

  // Synchroniser chain and edge history
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule

// ### core/tmw_pkg.sv
// Shared constants for the timer control, enable and status block
package tmw_pkg;
  // Register word offsets on the bus
  localparam logic [3:0] TMW_OFF_CONTROL = 4'h0;
  localparam logic [3:0] TMW_OFF_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] TMW_OFF_STATUS = 4'h2;
  localparam logic [3:0] TMW_OFF_COUNTER = 4'h3;
  localparam logic [3:0] TMW_OFF_GENERAL_A = 4'h4;
  localparam logic [3:0] TMW_OFF_GENERAL_B = 4'h5;
  localparam logic [3:0] TMW_OFF_GENERAL_C = 4'h6;
  localparam logic [3:0] TMW_OFF_GENERAL_D = 4'h7;
  localparam logic [3:0] TMW_OFF_CAPTURE_MODE = 4'h8;
  // Field positions
  localparam int TMW_BIT_CLEAR_ON_MATCH_A = 7;
  localparam int TMW_BIT_WRAP = 7;
  localparam int TMW_CKS_LSB = 4;
  // Reset values
  localparam logic [7:0] TMW_RST_CONTROL = 8'h00;
  localparam logic [7:0] TMW_RST_IRQ_ENABLE = 8'h00;
  localparam logic [15:0] TMW_RST_GENERAL = 16'hffff;
  localparam logic [15:0] TMW_RST_COUNTER = 16'h0000;
  // Reserved bits 6 to 4 always read as ones
  localparam logic [7:0] TMW_RESERVED_ONES = 8'h70;
  // Clock select codes
  localparam logic [2:0] TMW_CKS_DIV1 = 3'h0;
  localparam logic [2:0] TMW_CKS_DIV2 = 3'h1;
  localparam logic [2:0] TMW_CKS_DIV4 = 3'h2;
  localparam logic [2:0] TMW_CKS_DIV8 = 3'h3;
  // Prescaler width, clock period in ns
  localparam int TMW_PRESCALE_W = 3;
  localparam int TMW_CLK_PERIOD_NS = 20;
  localparam int TMW_WAIT_CYCLES = 1;
endpackage

// ### core/tmw_timer.sv
// Timer W counter, control, interrupt enable and status logic
// Operation
// R1 - Clear bit set clears counter on match A
// R2 - Clock select: divide 1/2/4/8 or external edges
// R3 - Undivided source counts subclock in sub modes
// R4 - Level D drives pin D until match D
// R5 - Level C drives pin C until match C
// R6 - Level B drives pin B until match B
// R7 - Level A drives pin A until match A
// R8 - Level bit write changes pin immediately
// R9 - Wrap enable passes wrap flag to request
// R10 - Channel D enable passes D flag
// R11 - Channel C enable passes C flag
// R12 - Channel B enable passes B flag
// R13 - Channel A enable passes A flag
// R14 - Reserved bits 6 to 4 read ones
// R15 - Wrap flag sets on all-ones to zero
// R16 - Wrap flag clears by read-one then write-zero
// R17 - Compare D match sets D flag
// R18 - Capture D copies counter, sets D flag
// R19 - D flag clears by read-one then write-zero
// R20 - Control register resets to zero
// R21 - Channel C flags on match or capture
// R22 - Request is flag AND enable
// R23 - Channels A,B like D; writing one ignored
`timescale 1ns/100ps
module tmw_timer
  import tmw_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Pins and chip mode
  input wire logic external_event_input_in,
  input wire logic [CHANNELS-1:0] capture_pin_in,
  input wire logic subclock_in,
  input wire logic sub_mode_in,
  output logic [CHANNELS-1:0] channel_pin_out,
  // Interrupt requests
  output logic wrap_irq_out,
  output logic [CHANNELS-1:0] chan_irq_out
);
  // Address decode helper, byte address to word index
  function automatic logic hit(input logic [5:0] addr, input logic [3:0] off);
    hit = (addr[5:2] == off) && (addr[1:0] == 2'b00);
  endfunction

  logic [7:0] control_q; // Clear bit, clock select, levels
  logic [7:0] irq_enable_q; // Wrap and channel enables
  logic [CHANNELS-1:0] capture_mode_q; // One per channel: 1 selects capture
  logic [15:0] main_counter_q; // Main 16-bit up-counter
  logic [15:0] general_q [CHANNELS]; // General registers A..D
  logic wrap_flag_q; // Wrap status
  logic [CHANNELS-1:0] chan_flag_q; // Channel status flags
  logic wrap_armed_q; // Flag seen as one by a read
  logic [CHANNELS-1:0] chan_armed_q; // Channel flags seen as one
  logic [CHANNELS-1:0] matched_q; // First match seen per channel
  logic [CHANNELS-1:0] pin_q; // Registered pin level
  logic [TMW_PRESCALE_W-1:0] prescale_q; // Free prescaler
  logic ack_q; // Bus answer phase
  logic [31:0] rdata_q; // Registered read data
  logic ext_rise; // Synchronised external edge
  logic sub_rise; // Synchronised subclock edge
  logic sub_mode_sync; // Synchronised sub mode level
  logic [CHANNELS-1:0] cap_rise; // Capture edges
  logic tick; // Counter advance strobe
  logic [CHANNELS-1:0] match; // Compare hits this cycle
  logic [CHANNELS-1:0] capture; // Capture hits this cycle
  logic wrap; // Counter wraps this cycle
  logic wr_en; // Accepted write
  logic rd_en; // Accepted read
  logic [7:0] status_view; // Status as software reads it
  logic [7:0] wbyte; // Lane 0 write data

  // External event, subclock and mode are asynchronous to the bus clock
  tmw_edge_sync u_ext (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(external_event_input_in),
    .level_out(),
    .rise_out(ext_rise)
  );
  tmw_edge_sync u_sub (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(subclock_in),
    .level_out(),
    .rise_out(sub_rise)
  );
  tmw_edge_sync u_mode (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(sub_mode_in),
    .level_out(sub_mode_sync),
    .rise_out()
  );

  // One synchroniser per capture pin
  for (genvar g = 0; g < CHANNELS; g++) begin : g_cap
    tmw_edge_sync u_cap (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .async_in(capture_pin_in[g]),
      .level_out(),
      .rise_out(cap_rise[g])
    );
  end

  // Bus strobes: one wait cycle, answer on the second edge
  assign wr_en = avs_write_in & ack_q;
  assign rd_en = avs_read_in & ack_q;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign wbyte = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;

  // Answer phase toggles so each request takes exactly two edges
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
    end
  end

  // Prescaler runs freely
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 3'h1;
    end
  end

  // Counter clock selection
  always_comb begin
    unique case (control_q[TMW_CKS_LSB+2 -: 3])
      TMW_CKS_DIV1: tick = sub_mode_sync ? sub_rise : 1'b1; // R2 R3
      TMW_CKS_DIV2: tick = prescale_q[0]; // R2
      TMW_CKS_DIV4: tick = &prescale_q[1:0]; // R2
      TMW_CKS_DIV8: tick = &prescale_q; // R2
      default: tick = ext_rise; // R2
    endcase
  end

  assign wrap = tick & (main_counter_q == 16'hffff); // R15

  // Compare and capture detection per channel
  for (genvar g = 0; g < CHANNELS; g++) begin : g_evt
    assign match[g] = ~capture_mode_q[g] & (main_counter_q == general_q[g]); // R17 R21 R23
    assign capture[g] = capture_mode_q[g] & cap_rise[g]; // R18 R21 R23
  end

  // Control, enable and capture mode registers, software only
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_q <= TMW_RST_CONTROL; // R20
      irq_enable_q <= TMW_RST_IRQ_ENABLE;
      capture_mode_q <= '0;
    end else if (wr_en) begin
      if (hit(avs_address_in, TMW_OFF_CONTROL) && avs_byteenable_in[0]) begin
        control_q <= wbyte;
      end
      if (hit(avs_address_in, TMW_OFF_IRQ_ENABLE) && avs_byteenable_in[0]) begin
        irq_enable_q <= wbyte & ~TMW_RESERVED_ONES;
      end
      if (hit(avs_address_in, TMW_OFF_CAPTURE_MODE) && avs_byteenable_in[0]) begin
        capture_mode_q <= wbyte[CHANNELS-1:0];
      end
    end
  end

  // Counter: software write has priority, then clear on match A
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_counter_q <= TMW_RST_COUNTER;
    end else if (wr_en && hit(avs_address_in, TMW_OFF_COUNTER)) begin
      main_counter_q <= avs_writedata_in[15:0];
    end else if (control_q[TMW_BIT_CLEAR_ON_MATCH_A] && match[0] && tick) begin
      main_counter_q <= TMW_RST_COUNTER; // R1
    end else if (tick) begin
      main_counter_q <= main_counter_q + 16'h0001;
    end
  end

  // General registers: capture beats a same-cycle software write
  for (genvar g = 0; g < CHANNELS; g++) begin : g_gen
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        general_q[g] <= TMW_RST_GENERAL;
      end else if (capture[g]) begin
        general_q[g] <= main_counter_q; // R18 R21 R23
      end else if (wr_en && hit(avs_address_in, TMW_OFF_GENERAL_A + 4'(g))) begin
        general_q[g] <= avs_writedata_in[15:0];
      end
    end
  end

  // Status as read; reserved bits forced high
  assign status_view = {wrap_flag_q, 3'b111, chan_flag_q} | TMW_RESERVED_ONES; // R14

  // Wrap flag: set wins over clear, clear needs prior read of one
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wrap_flag_q <= 1'b0;
      wrap_armed_q <= 1'b0;
    end else if (wrap) begin
      wrap_flag_q <= 1'b1; // R15
    end else if (wr_en && hit(avs_address_in, TMW_OFF_STATUS) && avs_byteenable_in[0]) begin
      if (!wbyte[TMW_BIT_WRAP] && wrap_armed_q) begin
        wrap_flag_q <= 1'b0; // R16
        wrap_armed_q <= 1'b0;
      end
    end else if (rd_en && hit(avs_address_in, TMW_OFF_STATUS) && wrap_flag_q) begin
      wrap_armed_q <= 1'b1; // R16
    end
  end

  // Channel flags follow the same discipline; writing one is ignored
  for (genvar g = 0; g < CHANNELS; g++) begin : g_flag
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        chan_flag_q[g] <= 1'b0;
        chan_armed_q[g] <= 1'b0;
      end else if (match[g] || capture[g]) begin
        chan_flag_q[g] <= 1'b1; // R17 R18 R21 R23
      end else if (wr_en && hit(avs_address_in, TMW_OFF_STATUS) && avs_byteenable_in[0]) begin
        if (!wbyte[g] && chan_armed_q[g]) begin
          chan_flag_q[g] <= 1'b0; // R19 R21 R23
          chan_armed_q[g] <= 1'b0;
        end
      end else if (rd_en && hit(avs_address_in, TMW_OFF_STATUS) && chan_flag_q[g]) begin
        chan_armed_q[g] <= 1'b1; // R19
      end
    end
  end

  // Output pins: level bit until first match, then toggle per match
  for (genvar g = 0; g < CHANNELS; g++) begin : g_pin
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        matched_q[g] <= 1'b0;
      end else if (wr_en && hit(avs_address_in, TMW_OFF_CONTROL) && avs_byteenable_in[0]) begin
        matched_q[g] <= 1'b0; // R8
      end else if (match[g]) begin
        matched_q[g] <= 1'b1;
      end
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        pin_q[g] <= 1'b0;
      end else if (wr_en && hit(avs_address_in, TMW_OFF_CONTROL) && avs_byteenable_in[0]) begin
        pin_q[g] <= wbyte[g]; // R8
      end else if (!matched_q[g] && !match[g]) begin
        pin_q[g] <= control_q[g]; // R4 R5 R6 R7
      end else if (match[g] && !(matched_q[g] && main_counter_q == general_q[g] && !tick)) begin
        pin_q[g] <= ~pin_q[g];
      end
    end
  end
  assign channel_pin_out = pin_q;

  // Interrupt requests are plain AND of flag and enable
  assign wrap_irq_out = wrap_flag_q & irq_enable_q[TMW_BIT_WRAP]; // R9 R22
  assign chan_irq_out = chan_flag_q & irq_enable_q[CHANNELS-1:0]; // R10 R11 R12 R13 R22

  // Read data registered at the first (wait) edge of a read; unmapped reads zero
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      if (hit(avs_address_in, TMW_OFF_CONTROL)) rdata_q[7:0] <= control_q;
      if (hit(avs_address_in, TMW_OFF_IRQ_ENABLE)) rdata_q[7:0] <= irq_enable_q | TMW_RESERVED_ONES; // R14
      if (hit(avs_address_in, TMW_OFF_STATUS)) rdata_q[7:0] <= status_view;
      if (hit(avs_address_in, TMW_OFF_COUNTER)) rdata_q[15:0] <= main_counter_q;
      if (hit(avs_address_in, TMW_OFF_CAPTURE_MODE)) rdata_q[CHANNELS-1:0] <= capture_mode_q;
      for (int i = 0; i < CHANNELS; i++) begin
        if (hit(avs_address_in, TMW_OFF_GENERAL_A + 4'(i))) rdata_q[15:0] <= general_q[i];
      end
    end
  end
endmodule

// ### verification/timer_w_control_status_tb_top.sv
// Self-checking bench for the timer control and status block
`timescale 1ns/100ps
module timer_w_control_status_tb_top import tmw_pkg::*; ();
  logic clk, nrst, rd, wr, waitreq, ev, subclk, submode, wirq;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, q, v, seed;
  logic [3:0] be, cap, pins, cirq;
  int num_errors, n_checks, cyc, c0, t0, t_take, dl, g;
  tmw_timer #(.CHANNELS(4)) tmw_timer_i (.ref_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .external_event_input_in(ev),
    .capture_pin_in(cap), .subclock_in(subclk), .sub_mode_in(submode), .channel_pin_out(pins),
    .wrap_irq_out(wirq), .chan_irq_out(cirq));
  tmw_pin_model tmw_pin_model_i (.ref_clk_in(clk), .event_out(ev), .capture_out(cap), .subclk_out(subclk));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [3:0] off, input logic [31:0] d);
    @(posedge clk);
    addr <= {off, 2'b00};
    wdata <= d;
    be <= 4'hf;
    rd <= !w;
    wr <= w;
    // Hold the request until waitrequest is seen low at a rising edge
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    t_take = cyc;
    rd <= 1'b0;
    wr <= 1'b0;
    // One more edge so a taken write shows on the outputs before compares
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cycle count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {nrst, rd, wr, submode, addr, wdata, be, num_errors, n_checks, cyc} = '0;
    seed = 32'h0000b5c7;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(0, TMW_OFF_CONTROL, 0); chk("control", q, 32'h0);
    bus(0, TMW_OFF_IRQ_ENABLE, 0); chk("enable", q, 32'h70);
    bus(0, TMW_OFF_STATUS, 0); chk("status", q, 32'h70);
    bus(0, 4'h9, 0); chk("unmapped", q, 32'h0);
    // Levels with the counter stopped, so no match can move the pins
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      bus(1, TMW_OFF_CONTROL, {24'h0, 4'h4, v[3:0]});
      bus(0, TMW_OFF_CONTROL, 0);
      chk("pins", pins, v[3:0]);
      chk("control", q, {24'h0, 4'h4, v[3:0]});
    end
    // Rate of each internal select; prescaler phase allows floor or ceiling
    for (int k = 0; k < 4; k++) begin
      bus(1, TMW_OFF_CONTROL, k << 4);
      bus(0, TMW_OFF_COUNTER, 0);
      c0 = q;
      t0 = t_take;
      repeat (60 + k) @(posedge clk);
      bus(0, TMW_OFF_COUNTER, 0);
      dl = (q - c0) & 32'hffff;
      g = t_take - t0;
      chk("rate", dl == (g >> k) || dl == ((g + (1 << k) - 1) >> k), 1);
    end
    // External edges, then subclock pulses in sub mode
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      submode <= k[0];
      bus(1, TMW_OFF_CONTROL, k ? 32'h0 : {25'h0, 1'b1, v[1:0], 4'h0});
      bus(0, TMW_OFF_COUNTER, 0);
      c0 = q;
      tmw_pin_model_i.pulse(k, 5 - 2 * k, 3);
      bus(0, TMW_OFF_COUNTER, 0);
      chk("edges", (q - c0) & 32'hffff, 5 - 2 * k);
    end
    submode <= 1'b0;
    // Wrap by external edges; flag clears only after read of one then write of zero
    bus(1, TMW_OFF_IRQ_ENABLE, 32'h80);
    bus(1, TMW_OFF_CONTROL, 32'h40);
    bus(1, TMW_OFF_COUNTER, 32'hfffd);
    tmw_pin_model_i.pulse(0, 4, 3);
    chk("wrap irq", wirq, 1);
    bus(1, TMW_OFF_STATUS, 0);
    bus(0, TMW_OFF_STATUS, 0); chk("wrap kept", q[7], 1);
    bus(1, TMW_OFF_STATUS, 0);
    bus(0, TMW_OFF_STATUS, 0); chk("wrap gone", q[7], 0);
    chk("wrap irq", wirq, 0);
    bus(1, TMW_OFF_STATUS, 32'hff);
    bus(0, TMW_OFF_STATUS, 0); chk("ones ignored", q, 32'h70);
    // Compare on each channel against the stopped counter
    v = rnd() & 32'h7fff;
    bus(1, TMW_OFF_COUNTER, v);
    for (int ch = 0; ch < 4; ch++) begin
      bus(1, 4'(TMW_OFF_GENERAL_A + ch), v);
      bus(0, TMW_OFF_STATUS, 0); chk("match flag", q[ch], 1);
    end
    bus(1, TMW_OFF_IRQ_ENABLE, 32'h05); chk("irq", cirq, 4'h5);
    bus(1, TMW_OFF_IRQ_ENABLE, 32'h0a); chk("irq", cirq, 4'ha);
    for (int ch = 0; ch < 4; ch++) bus(1, 4'(TMW_OFF_GENERAL_A + ch), 32'hffff);
    bus(0, TMW_OFF_STATUS, 0);
    bus(1, TMW_OFF_STATUS, 0);
    bus(0, TMW_OFF_STATUS, 0); chk("flags gone", q, 32'h70);
    // Capture on D copies the counter
    bus(1, TMW_OFF_CAPTURE_MODE, 32'h8);
    tmw_pin_model_i.pulse(5, 1, 3);
    bus(0, TMW_OFF_GENERAL_D, 0); chk("capture", q, v);
    chk("irq", cirq, 4'h8);
    bus(1, TMW_OFF_STATUS, 0);
    bus(0, TMW_OFF_STATUS, 0); chk("d kept", q[3], 1);
    bus(1, TMW_OFF_STATUS, 0); chk("irq", cirq, 4'h0);
    // Clear on match A, then free running
    bus(1, TMW_OFF_CAPTURE_MODE, 0);
    bus(1, TMW_OFF_GENERAL_A, 32'h10);
    bus(1, TMW_OFF_IRQ_ENABLE, 32'h01);
    bus(1, TMW_OFF_COUNTER, 0);
    bus(1, TMW_OFF_CONTROL, 32'h80);
    repeat (40) @(posedge clk);
    bus(0, TMW_OFF_COUNTER, 0); chk("cleared", q <= 32'h10, 1);
    chk("irq a", cirq[0], 1);
    bus(1, TMW_OFF_CONTROL, 32'h00);
    repeat (40) @(posedge clk);
    bus(0, TMW_OFF_COUNTER, 0); chk("free run", q > 32'h10, 1);
    results();
  end
endmodule

// ### verification/tmw_pin_model.sv
// Model of the event, capture and subclock sources at the timer pins
`timescale 1ns/100ps
module tmw_pin_model (
  input wire logic ref_clk_in,
  output logic event_out,
  output logic [3:0] capture_out,
  output logic subclk_out
);
  logic [5:0] line_q = 6'h00; // Idle low; 0 event, 1 subclock, 2..5 capture
  assign event_out = line_q[0];
  assign subclk_out = line_q[1];
  assign capture_out = line_q[5:2];
  // Pulses of w cycles each side, so the two sync stages see every level
  task automatic pulse(input int kind, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      line_q[kind] <= 1'b1;
      repeat (w) @(posedge ref_clk_in);
      line_q[kind] <= 1'b0;
      repeat (w) @(posedge ref_clk_in);
    end
  endtask
endmodule

// ### verification/tmw_timer_assertions.sv
// Port checker for the timer control and status block
`timescale 1ns/100ps
module tmw_timer_chk
  import tmw_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic external_event_input_in,
  input wire logic [CHANNELS-1:0] capture_pin_in,
  input wire logic subclock_in,
  input wire logic sub_mode_in,
  input wire logic [CHANNELS-1:0] channel_pin_out,
  input wire logic wrap_irq_out,
  input wire logic [CHANNELS-1:0] chan_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] en_q; // Shadow of the enable register
  logic [7:0] ctl_q; // Shadow of the control register
  logic wr_ok; // Write taken with lane 0
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  // Shadows follow writes at the edge the block takes them
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_q <= 8'h00;
      ctl_q <= 8'h00;
    end else if (wr_ok && avs_address_in == {TMW_OFF_IRQ_ENABLE, 2'b00}) begin
      en_q <= avs_writedata_in[7:0];
    end else if (wr_ok && avs_address_in == {TMW_OFF_CONTROL, 2'b00}) begin
      ctl_q <= avs_writedata_in[7:0];
    end
  end
  sequence s_rd_taken;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  sequence s_ctl_taken;
    wr_ok && avs_address_in == {TMW_OFF_CONTROL, 2'b00};
  endsequence
  a_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("new request not held off");
  a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait lasted over one cycle");
  a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait raised with no request");
  a_reserved_ones: assert property (s_rd_taken ##0 (avs_address_in == 6'h04 || avs_address_in == 6'h08)
    |-> avs_readdata_out[6:4] == 3'h7) else $error("reserved bits not ones");
  a_unmapped_zero: assert property (s_rd_taken ##0 avs_address_in > 6'h20 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (s_rd_taken |-> avs_readdata_out[31:16] == 16'h0)
    else $error("upper read lanes not zero");
  a_wrap_masked: assert property (wrap_irq_out |-> en_q[7])
    else $error("wrap request without enable");
  a_chan_masked: assert property ((chan_irq_out & ~en_q[CHANNELS-1:0]) == '0)
    else $error("channel request without enable");
  a_pin_follow: assert property (s_ctl_taken |=> ##[0:1] channel_pin_out == ctl_q[CHANNELS-1:0])
    else $error("pin level not applied");
endmodule
bind tmw_timer tmw_timer_chk #(.CHANNELS(CHANNELS)) tmw_timer_chk_i (.ref_clk_in, .nrst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .external_event_input_in, .capture_pin_in, .subclock_in, .sub_mode_in, .channel_pin_out, .wrap_irq_out,
  .chan_irq_out);
